//--- design/supervisor_consts.svh
/*
 * Constants of the supply reset and watchdog supervisor: APB register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 10 MHz pclk; included by the package and the supervisor module.
 */
// What this block does
// - reset held low while supply not good
// - reset asserted at power-up, power-down, brownout
// - good supply starts timer, release after timeout
// - supply loss drives reset low once the filter fills
// - below-threshold input integrated before asserting reset
// - timeout mode: any kick edge restarts period
// - window mode: only falling kick edges count
// - window: third edge in lower period faults
// - window: no falling edge by upper boundary faults
// - kick edges blanked after output rising edges
// - upper boundary is exactly 31 lower periods
// - fault runs reset timer, then returns high
// - kick edges ignored while fault timer runs
// - idle kick gives repeating fault pulse train
// - fault and supply reset never low together
// - watchdog off while off-select input high
// - mode input low selects window, high timeout
// - disabled watchdog ignores idle-high kick input
`ifndef SUPERVISOR_CONSTS_SVH
`define SUPERVISOR_CONSTS_SVH

`define CLK_PERIOD_NS      100
// register byte offsets
`define REG_RESET_PERIOD   8'h00
`define REG_LOWER_PERIOD   8'h04
`define REG_FILTER_LEN     8'h08
`define REG_STATUS         8'h0c
// register widths
`define RESET_PERIOD_W     24
`define LOWER_PERIOD_W     20
`define UPPER_PERIOD_W     25
`define FILTER_LEN_W       8
// reset values: 20 ms reset, 3 ms lower boundary, 8-cycle filter
`define RESET_PERIOD_MS    20
`define LOWER_PERIOD_MS    3
`define RESET_PERIOD_RST   24'(`RESET_PERIOD_MS * 1000000 / `CLK_PERIOD_NS)
`define LOWER_PERIOD_RST   20'(`LOWER_PERIOD_MS * 1000000 / `CLK_PERIOD_NS)
`define FILTER_LEN_RST     8'h08
// upper = lower * 31
`define UPPER_RATIO_SHIFT  5
// blanking interval is the lower period divided by 2**shift
`define BLANK_SHIFT        3
`define WINDOW_EDGE_LIMIT  2'h2
// status field positions
`define ST_RESET_N_BIT     0
`define ST_FAULT_N_BIT     1
`define ST_SUPPLY_BIT      2
`define ST_MODE_BIT        3
`define ST_OFF_BIT         4
`define ST_BELOW_BIT       5

`endif

//--- design/supervisor_pkg.sv
/*
 * Types of the supervisor: APB request and response carriers, state enums.
 * Assumes supervisor_consts.svh is on the include path.
 */
`include "supervisor_consts.svh"
package supervisor_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef enum logic [1:0] {
        SUP_LOW    = 2'b00,
        SUP_TIMING = 2'b01,
        SUP_OK     = 2'b10
    } sup_state_t;

    typedef enum logic [1:0] {
        WD_IDLE  = 2'b00,
        WD_BLANK = 2'b01,
        WD_RUN   = 2'b10,
        WD_FAULT = 2'b11
    } wd_state_t;
endpackage

//--- design/supply_reset_and_watchdog.sv
/*
 * Supply reset and watchdog supervisor with APB-programmable periods.
 * Assumes: pins power_good, watchdog_kick, watchdog_off_select and
 * window_timeout_select are asynchronous; APB master on pclk.
 */
`timescale 1ns/1ps
`include "supervisor_consts.svh"
module supply_reset_and_watchdog (
    // clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // apb
    input  wire supervisor_pkg::apb_req_t apb_req,
    output supervisor_pkg::apb_rsp_t      apb_rsp,
    // pins
    input  wire logic                    power_good,
    input  wire logic                    watchdog_kick,
    input  wire logic                    watchdog_off_select,
    input  wire logic                    window_timeout_select,
    output logic                         supply_reset_n,
    output logic                         watchdog_fault_n
);
    import supervisor_pkg::*;

    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    logic       kick_d_reg;
    logic       pg_s;
    logic       kick_s;
    logic       off_s;
    logic       timeout_mode;
    logic       kick_rise;
    logic       kick_fall;

    logic [`RESET_PERIOD_W-1:0] reset_period_reg;
    logic [`LOWER_PERIOD_W-1:0] lower_period_reg;
    logic [`FILTER_LEN_W-1:0]   filter_len_reg;
    logic [`UPPER_PERIOD_W-1:0] upper_cycles;
    logic [`UPPER_PERIOD_W-1:0] blank_cycles;
    logic [`UPPER_PERIOD_W-1:0] reset_cycles;
    logic [`UPPER_PERIOD_W-1:0] lower_cycles;

    logic [`FILTER_LEN_W-1:0]   filt_cnt_reg;
    logic                       below_reg;
    sup_state_t                 sup_reg;
    sup_state_t                 sup_next;
    logic [`RESET_PERIOD_W-1:0] sup_cnt_reg;
    wd_state_t                  wd_reg;
    wd_state_t                  wd_next;
    logic [`UPPER_PERIOD_W-1:0] wd_cnt_reg;
    logic [1:0]                 edge_cnt_reg;
    logic                       wd_enable;
    logic                       wd_edge;

    logic        pready_reg;
    logic        pslverr_reg;
    logic [31:0] prdata_reg;
    logic        supply_reset_n_reg;
    logic        watchdog_fault_n_reg;
    logic        access;
    logic [31:0] wdata;

    // two-flop synchronisers, one per pin
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            logic pin;
            assign pin = (g == 0) ? power_good : (g == 1) ? watchdog_kick :
                         (g == 2) ? watchdog_off_select : window_timeout_select;
            always_ff @(posedge pclk or negedge presetn) begin
                // kick rests at its pull-up level, so reset makes no false edge
                if (!presetn) begin
                    meta_reg[g] <= (g == 1);
                    sync_reg[g] <= (g == 1);
                end else begin
                    meta_reg[g] <= pin;
                    sync_reg[g] <= meta_reg[g];
                end
            end
        end
    endgenerate

    assign pg_s         = sync_reg[0];
    assign kick_s       = sync_reg[1];
    assign off_s        = sync_reg[2];
    assign timeout_mode = sync_reg[3];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kick_d_reg <= 1'b1;
        end else begin
            kick_d_reg <= kick_s;
        end
    end

    assign kick_rise = kick_s & ~kick_d_reg;
    assign kick_fall = ~kick_s & kick_d_reg;

    // derived periods; upper tracks lower so the ratio cannot drift
    // blanking scales with the lower period so short settings stay usable
    assign lower_cycles = `UPPER_PERIOD_W'(lower_period_reg);
    assign upper_cycles = (lower_cycles << `UPPER_RATIO_SHIFT) - lower_cycles;
    assign reset_cycles = `UPPER_PERIOD_W'(reset_period_reg);
    assign blank_cycles = ((lower_cycles >> `BLANK_SHIFT) == '0) ? `UPPER_PERIOD_W'(1)
                          : (lower_cycles >> `BLANK_SHIFT);

    // apb slave: one wait state, writes land with pready high
    // status is read-only; writes to it are dropped without an error
    assign access = apb_req.psel & apb_req.penable;
    assign wdata  = apb_req.pwdata;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else if (access && !pready_reg) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            case (apb_req.paddr)
                `REG_RESET_PERIOD: prdata_reg <= 32'(reset_period_reg);
                `REG_LOWER_PERIOD: prdata_reg <= 32'(lower_period_reg);
                `REG_FILTER_LEN:   prdata_reg <= 32'(filter_len_reg);
                `REG_STATUS: begin
                    prdata_reg[`ST_RESET_N_BIT] <= supply_reset_n_reg;
                    prdata_reg[`ST_FAULT_N_BIT] <= watchdog_fault_n_reg;
                    prdata_reg[`ST_SUPPLY_BIT]  <= pg_s;
                    prdata_reg[`ST_MODE_BIT]    <= timeout_mode;
                    prdata_reg[`ST_OFF_BIT]     <= off_s;
                    prdata_reg[`ST_BELOW_BIT]   <= below_reg;
                end
                default: pslverr_reg <= 1'b1;
            endcase
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // zero would make the counters wrap, so it is stored as one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_period_reg <= `RESET_PERIOD_RST;
            lower_period_reg <= `LOWER_PERIOD_RST;
            filter_len_reg   <= `FILTER_LEN_RST;
        end else if (access && pready_reg && apb_req.pwrite) begin
            case (apb_req.paddr)
                `REG_RESET_PERIOD: reset_period_reg <= (wdata[`RESET_PERIOD_W-1:0] == '0) ?
                    `RESET_PERIOD_W'(1) : wdata[`RESET_PERIOD_W-1:0];
                `REG_LOWER_PERIOD: lower_period_reg <= (wdata[`LOWER_PERIOD_W-1:0] == '0) ?
                    `LOWER_PERIOD_W'(1) : wdata[`LOWER_PERIOD_W-1:0];
                `REG_FILTER_LEN: filter_len_reg <= (wdata[`FILTER_LEN_W-1:0] == '0) ?
                    `FILTER_LEN_W'(1) : wdata[`FILTER_LEN_W-1:0];
                default: ;
            endcase
        end
    end

    // integrating filter: below is declared at full count, cleared at zero
    // a longer filter rides out dips but delays a genuine brownout reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_cnt_reg <= `FILTER_LEN_RST;
            below_reg    <= 1'b1;
        end else begin
            if (!pg_s && filt_cnt_reg < filter_len_reg) begin
                filt_cnt_reg <= filt_cnt_reg + 1'b1;
            end else if (pg_s && filt_cnt_reg != '0) begin
                filt_cnt_reg <= filt_cnt_reg - 1'b1;
            end else if (filt_cnt_reg > filter_len_reg) begin
                filt_cnt_reg <= filter_len_reg;
            end
            if (!pg_s && filt_cnt_reg + 1'b1 >= filter_len_reg) begin
                below_reg <= 1'b1;
            end else if (pg_s && filt_cnt_reg <= 8'h01) begin
                below_reg <= 1'b0;
            end
        end
    end

    // supply reset sequencer
    // a supply drop skips the timer; release always waits a full period
    always_comb begin
        sup_next = sup_reg;
        case (sup_reg)
            SUP_LOW:    if (!below_reg) sup_next = SUP_TIMING;
            SUP_TIMING: if (below_reg) sup_next = SUP_LOW;
                        else if (sup_cnt_reg >= reset_period_reg - 1'b1) sup_next = SUP_OK;
            SUP_OK:     if (below_reg) sup_next = SUP_LOW;
            default:    sup_next = SUP_LOW;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_reg     <= SUP_LOW;
            sup_cnt_reg <= '0;
        end else begin
            sup_reg     <= sup_next;
            sup_cnt_reg <= (sup_reg == SUP_TIMING && sup_next == SUP_TIMING) ?
                           sup_cnt_reg + 1'b1 : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_reset_n_reg <= 1'b0;
        end else begin
            supply_reset_n_reg <= (sup_next == SUP_OK);
        end
    end

    // watchdog: idle kick pin stays high, so a disabled watchdog sees nothing
    assign wd_enable = !off_s && (sup_next == SUP_OK);
    assign wd_edge   = timeout_mode ? (kick_rise | kick_fall) : kick_fall;

    always_comb begin
        wd_next = wd_reg;
        case (wd_reg)
            WD_IDLE:  wd_next = WD_BLANK;
            WD_BLANK: if (wd_cnt_reg >= blank_cycles - 1'b1) wd_next = WD_RUN;
            WD_RUN: begin
                if (!timeout_mode && kick_fall && wd_cnt_reg < lower_cycles &&
                    edge_cnt_reg == `WINDOW_EDGE_LIMIT) begin
                    wd_next = WD_FAULT;
                end else if (!wd_edge && wd_cnt_reg >= upper_cycles - 1'b1) begin
                    wd_next = WD_FAULT;
                end
            end
            WD_FAULT: if (wd_cnt_reg >= reset_cycles - 1'b1) wd_next = WD_BLANK;
            default:  wd_next = WD_IDLE;
        endcase
        if (!wd_enable) begin
            wd_next = WD_IDLE;
        end
    end

    // early window edges are counted, not restarted, until the lower boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_reg       <= WD_IDLE;
            wd_cnt_reg   <= '0;
            edge_cnt_reg <= 2'h0;
        end else begin
            wd_reg <= wd_next;
            if (wd_next != wd_reg) begin
                wd_cnt_reg   <= '0;
                edge_cnt_reg <= 2'h0;
            end else if (wd_reg == WD_RUN && wd_edge) begin
                if (timeout_mode || wd_cnt_reg >= lower_cycles) begin
                    wd_cnt_reg   <= '0;
                    edge_cnt_reg <= 2'h0;
                end else begin
                    wd_cnt_reg   <= wd_cnt_reg + 1'b1;
                    edge_cnt_reg <= edge_cnt_reg + 2'h1;
                end
            end else begin
                // fault and blank states count without looking at the kick
                wd_cnt_reg <= wd_cnt_reg + 1'b1;
            end
        end
    end

    // supply reset low forces IDLE, which frees the fault output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_fault_n_reg <= 1'b1;
        end else begin
            watchdog_fault_n_reg <= (wd_next != WD_FAULT);
        end
    end

    assign apb_rsp          = '{prdata: prdata_reg, pready: pready_reg, pslverr: pslverr_reg};
    assign supply_reset_n   = supply_reset_n_reg;
    assign watchdog_fault_n = watchdog_fault_n_reg;

    // sequencer checks; each watches state the design drives
    sequence s_fault_done;
        (wd_reg == WD_FAULT) ##1 (wd_reg == WD_BLANK);
    endsequence

    sequence s_supply_lost;
        (sup_reg == SUP_OK) ##1 below_reg;
    endsequence

    reset_on_loss_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_supply_lost |=> !supply_reset_n)
        else $error("supply reset not asserted after supply loss");
    low_while_below_a: assert property (@(posedge pclk) disable iff (!presetn)
        below_reg |=> !supply_reset_n)
        else $error("supply reset high while supply below threshold");
    filter_integrates_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(below_reg) |-> !$past(pg_s) && filt_cnt_reg >= filter_len_reg - 8'h01)
        else $error("reset asserted before filter count reached");
    release_timed_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(supply_reset_n) |-> $past(sup_reg) == SUP_TIMING &&
        $past(sup_cnt_reg) >= reset_period_reg - 1'b1)
        else $error("supply reset released before timeout");
    never_both_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(!supply_reset_n && !watchdog_fault_n))
        else $error("fault and supply reset low together");
    disabled_no_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
        off_s |=> watchdog_fault_n && wd_reg == WD_IDLE)
        else $error("fault while watchdog disabled");
    fault_length_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_fault_done |-> $past(wd_cnt_reg) >= reset_cycles - 1'b1)
        else $error("fault ended before reset period");
    train_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_fault_done |-> watchdog_fault_n)
        else $error("fault output not released after reset period");
    timeout_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wd_reg == WD_RUN && timeout_mode && (kick_rise || kick_fall) && wd_next == WD_RUN)
        |=> wd_cnt_reg == '0)
        else $error("kick edge did not restart timeout");
    rise_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wd_reg == WD_RUN && !timeout_mode && kick_rise && wd_next == WD_RUN)
        |=> wd_cnt_reg == $past(wd_cnt_reg) + 1'b1)
        else $error("rising edge affected window watchdog");
    window_late_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wd_reg == WD_RUN && wd_next == WD_FAULT && !kick_fall && !timeout_mode)
        |-> wd_cnt_reg >= upper_cycles - 1'b1 ##1 !watchdog_fault_n)
        else $error("window fault before upper boundary");
    blank_ignores_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wd_reg == WD_BLANK && wd_next == WD_BLANK) |=> edge_cnt_reg == 2'h0 &&
        wd_cnt_reg == $past(wd_cnt_reg) + 1'b1)
        else $error("kick edge acted during blanking");

    sequence s_blank_done;
        (wd_reg == WD_BLANK) ##1 (wd_reg == WD_RUN);
    endsequence

    // supply reset checks
    timing_holds_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sup_reg == SUP_TIMING) |-> !supply_reset_n)
        else $error("supply reset released while timer runs");
    loss_frees_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(supply_reset_n) |-> watchdog_fault_n && wd_reg == WD_IDLE)
        else $error("fault still low after supply reset asserted");
    filter_absorbs_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!below_reg && pg_s) |=> !below_reg)
        else $error("below flag set while supply good");
    below_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(below_reg) |-> $past(pg_s) && $past(filt_cnt_reg) <= 8'h01)
        else $error("below flag cleared before filter drained");

    // watchdog checks
    timeout_late_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wd_reg == WD_RUN && timeout_mode && wd_next == WD_FAULT)
        |-> !kick_rise && !kick_fall && wd_cnt_reg >= upper_cycles - 1'b1)
        else $error("timeout fault without a full quiet period");
    window_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wd_reg == WD_RUN && !timeout_mode && kick_fall && wd_cnt_reg >= lower_cycles && wd_next == WD_RUN)
        |=> wd_cnt_reg == '0)
        else $error("falling edge in window did not restart period");
    third_edge_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wd_reg == WD_RUN && wd_enable && !timeout_mode && kick_fall && wd_cnt_reg < lower_cycles &&
        edge_cnt_reg == `WINDOW_EDGE_LIMIT) |=> !watchdog_fault_n)
        else $error("third early falling edge did not fault");
    fault_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(watchdog_fault_n) |-> $past(wd_cnt_reg) >= $past(upper_cycles) - 1'b1 ||
        $past(edge_cnt_reg) == `WINDOW_EDGE_LIMIT)
        else $error("fault without a late or crowded kick");
    enable_starts_blank_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wd_reg == WD_IDLE && wd_enable) |=> wd_reg == WD_BLANK)
        else $error("watchdog skipped blanking after enable");
    blank_exit_clean_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_blank_done |-> wd_cnt_reg == '0 && edge_cnt_reg == 2'h0)
        else $error("blanked edges left a trace");
    fault_ignores_kick_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wd_reg == WD_FAULT && wd_next == WD_FAULT) |=> edge_cnt_reg == 2'h0 &&
        wd_cnt_reg == $past(wd_cnt_reg) + 1'b1)
        else $error("kick edge acted during fault");
    watchdog_on_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wd_reg != WD_IDLE) |-> !$past(off_s))
        else $error("watchdog ran while switched off");
endmodule

//--- verification/kick_source.sv
/*
 * Processor model that drives the watchdog kick pin.
 * Assumes pclk and presetn from the bench; half_period 0 keeps the kick idle high.
 */
`timescale 1ns/1ps
module kick_source (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // control from the bench
    input  wire logic       supply_reset_n,
    input  wire logic [7:0] half_period,
    // kick pin
    output logic            watchdog_kick
);
    logic [7:0] cnt_reg;

    // a processor held in reset cannot kick, so the pin rests at its pull-up level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg       <= 8'h00;
            watchdog_kick <= 1'b1;
        end else if (!supply_reset_n || half_period == 8'h00) begin
            cnt_reg       <= 8'h00;
            watchdog_kick <= 1'b1;
        end else if (cnt_reg + 8'h01 >= half_period) begin
            cnt_reg       <= 8'h00;
            watchdog_kick <= ~watchdog_kick;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule

//--- verification/supply_reset_and_watchdog_test.sv
/*
 * Self-checking bench of the supply reset and watchdog supervisor.
 * Assumes the supervisor package, its constants header and the kick_source model.
 */
`timescale 1ns/1ps
`include "supervisor_consts.svh"
module supply_reset_and_watchdog_test;
    import supervisor_pkg::*;
    logic        pclk                  = 1'b0;
    logic        presetn               = 1'b0;
    apb_req_t    apb_req               = '0;
    apb_rsp_t    apb_rsp;
    logic        power_good            = 1'b0;
    logic        watchdog_kick;
    logic        watchdog_off_select   = 1'b1;
    logic        window_timeout_select = 1'b1;
    logic        supply_reset_n;
    logic        watchdog_fault_n;
    logic [7:0]  half_period           = 8'h00;
    logic [31:0] rd;
    logic        er;
    int          n;
    int          err_count             = 0;
    int          checks                = 0;

    always #50 pclk = ~pclk;

    supply_reset_and_watchdog supply_reset_and_watchdog_i (
        .pclk                  (pclk),
        .presetn               (presetn),
        .apb_req               (apb_req),
        .apb_rsp               (apb_rsp),
        .power_good            (power_good),
        .watchdog_kick         (watchdog_kick),
        .watchdog_off_select   (watchdog_off_select),
        .window_timeout_select (window_timeout_select),
        .supply_reset_n        (supply_reset_n),
        .watchdog_fault_n      (watchdog_fault_n)
    );

    kick_source kick_source_i (
        .pclk           (pclk),
        .presetn        (presetn),
        .supply_reset_n (supply_reset_n),
        .half_period    (half_period),
        .watchdog_kick  (watchdog_kick)
    );

    task automatic report_and_stop();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_range(input int got, input int lo, input int hi, input string what);
        checks++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("mismatch at %0t: %s took %0d cycles", $time, what, got);
        end
    endtask

    // one apb transfer; the request stands until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int k;
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (apb_rsp.pready !== 1'b1 && k < 20);
        rd = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        apb_req <= '0;
        if (k >= 20) begin
            err_count++;
            $display("mismatch at %0t: no pready", $time);
            report_and_stop();
        end
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input string what);
        apb(1'b0, addr, 32'h0);
        check_val(rd, exp, what);
    endtask

    // counts edges until the chosen output shows lvl
    task automatic wait_for(input bit fault, input logic lvl, input int max);
        n = 0;
        while ((fault ? watchdog_fault_n : supply_reset_n) !== lvl) begin
            @(posedge pclk);
            n++;
            if (n > max) begin
                err_count++;
                $display("mismatch at %0t: output level never came", $time);
                report_and_stop();
            end
        end
    endtask

    task automatic hold(input bit fault, input logic lvl, input int cyc, input string what);
        logic bad;
        bad = 1'b0;
        repeat (cyc) begin
            @(posedge pclk);
            if ((fault ? watchdog_fault_n : supply_reset_n) !== lvl) bad = 1'b1;
        end
        check_val(bad, 1'b0, what);
    endtask

    always @(posedge pclk) begin
        if (presetn === 1'b1 && supply_reset_n === 1'b0 && watchdog_fault_n === 1'b0) begin
            err_count++;
            $display("mismatch at %0t: fault and supply reset low together", $time);
        end
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        check_val(supply_reset_n, 1'b0, "reset at power-up");
        check_val(watchdog_fault_n, 1'b1, "fault idle at reset");
        rd_chk(`REG_RESET_PERIOD, 32'h00030d40, "reset period");
        rd_chk(`REG_LOWER_PERIOD, 32'h00007530, "lower period");
        rd_chk(`REG_FILTER_LEN, 32'h00000008, "filter length");
        apb(1'b1, 8'h10, 32'h00000001);
        check_val(er, 1'b1, "unmapped error");
        apb(1'b1, `REG_LOWER_PERIOD, 32'h00000000);
        rd_chk(`REG_LOWER_PERIOD, 32'h00000001, "zero period");
        apb(1'b1, `REG_RESET_PERIOD, 32'h0000000a);
        apb(1'b1, `REG_LOWER_PERIOD, 32'h00000004);
        apb(1'b1, `REG_FILTER_LEN, 32'h00000004);
        apb(1'b0, `REG_STATUS, 32'h0);
        check_val(rd & 32'h18, 32'h18, "timeout mode and off");
        power_good <= 1'b1;
        wait_for(1'b0, 1'b1, 40);
        check_range(n, 10, 30, "reset timeout");
        rd_chk(`REG_STATUS, 32'h0000001f, "status with supply good");
        power_good <= 1'b0;
        repeat (2) @(posedge pclk);
        power_good <= 1'b1;
        hold(1'b0, 1'b1, 20, "short dip absorbed");
        power_good <= 1'b0;
        wait_for(1'b0, 1'b0, 12);
        check_range(n, 4, 10, "brownout reset");
        hold(1'b0, 1'b0, 30, "reset held while low");
        rd_chk(`REG_STATUS, 32'h0000003a, "status in brownout");
        power_good <= 1'b1;
        wait_for(1'b0, 1'b1, 40);
        watchdog_off_select <= 1'b0;
        wait_for(1'b1, 1'b0, 200);
        check_range(n, 124, 132, "timeout high time");
        wait_for(1'b1, 1'b1, 40);
        check_range(n, 10, 11, "fault low time");
        wait_for(1'b1, 1'b0, 200);
        check_range(n, 124, 128, "train high time");
        half_period <= 8'd2;
        wait_for(1'b1, 1'b1, 40);
        check_range(n, 10, 11, "kicks ignored in fault");
        hold(1'b1, 1'b1, 400, "fast kicks keep fault off");
        half_period <= 8'd70;
        hold(1'b1, 1'b1, 500, "slow toggles keep fault off");
        window_timeout_select <= 1'b0;
        wait_for(1'b1, 1'b0, 300);
        wait_for(1'b1, 1'b1, 40);
        half_period <= 8'd40;
        hold(1'b1, 1'b1, 600, "falling edges in window");
        apb(1'b1, `REG_LOWER_PERIOD, 32'h00000028);
        half_period <= 8'd2;
        wait_for(1'b1, 1'b0, 40);
        check_range(n, 0, 40, "edges too close");
        half_period <= 8'd0;
        wait_for(1'b1, 1'b1, 40);
        apb(1'b1, `REG_LOWER_PERIOD, 32'h00000004);
        wait_for(1'b1, 1'b0, 300);
        power_good <= 1'b0;
        wait_for(1'b0, 1'b0, 12);
        check_val(watchdog_fault_n, 1'b1, "fault released by reset");
        power_good <= 1'b1;
        wait_for(1'b0, 1'b1, 40);
        watchdog_off_select <= 1'b1;
        hold(1'b1, 1'b1, 400, "disabled with idle kick");
        report_and_stop();
    end
endmodule
